// [verilog/lcm_consts.vh]
// Behaviour
// - a three-bit sticky read-write transmit margin field sits at bits 9:7 and resets to zero.
// - the transmit margin field clears to zero when training enters the polling configuration substate.
// - margin codes 0 normal, 1..5 successively lower levels, 6 and 7 reserved; the field stores and applies 6 and 7 like any other code.
// - with margin code zero the drive level comes from the serdes level control registers.
// - a newly written margin is applied to the line only when training passes recovery receiver lock.
// - with bit 10 set, polling compliance sends the modified compliance pattern.
// - with bit 11 set, skip ordered sets are inserted between compliance patterns.
// - bit 12 picks compliance de-emphasis when entered by force compliance, 0 is -6.0 dB, 1 is -3.5 dB.
`ifndef LCM_CONSTS_VH
`define LCM_CONSTS_VH
`define LCM_ADDR_W 12
`define LCM_OFS_CTL2 12'h070
`define LCM_MARGIN_LSB 7
`define LCM_MARGIN_MSB 9
`define LCM_MC_BIT 10
`define LCM_SKIP_BIT 11
`define LCM_DEEMPH_BIT 12
`define LCM_MARGIN_RST 3'h0
`define LCM_MARGIN_NORMAL 3'h0
`define LCM_MARGIN_MAX_VALID 3'h5
`define LCM_ST_W 4
`define LCM_ST_OTHER 4'h0
`define LCM_ST_POLL_CFG 4'h1
`define LCM_ST_POLL_COMP 4'h2
`define LCM_ST_RCV_LOCK 4'h3
`endif

// [verilog/lcm_margin_apply.v]
`timescale 1ns/10ps
`include "lcm_consts.vh"
// holds the margin seen by the transmitter, updated only at receiver lock
module lcm_margin_apply (
    input wire i_clk,
    input wire i_rst,
    input wire [2:0] i_margin_reg,
    input wire i_in_rcv_lock,
    output reg [2:0] o_margin_line
);
    // the line must not change mid-frame, so only lock may load it
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_margin_line <= `LCM_MARGIN_RST;
        end else if (i_in_rcv_lock) begin
            o_margin_line <= i_margin_reg;
        end
    end
endmodule // lcm_margin_apply

// [verilog/lcm_link_ctl2.v]
`timescale 1ns/10ps
`include "lcm_consts.vh"
// upper half of link control 2: margin and compliance controls
module lcm_link_ctl2 (
    input wire i_clk,
    input wire i_rst,
    input wire [11:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [15:0] o_rdata,
    input wire [3:0] i_ltssm_state,
    input wire i_comp_by_force,
    input wire [2:0] i_serdes_level,
    output reg [2:0] o_tx_margin_line,
    output reg o_use_serdes_level,
    output reg [2:0] o_tx_level,
    output reg o_send_modified_comp,
    output reg o_skip_insert_en,
    output reg o_comp_deemph_3p5,
    output reg o_apply_deemph_override
);
    // the three single-bit compliance controls, bits 10 up to 12
    localparam FLAG_N = 3;
    localparam FLAG_MC = 0;
    localparam FLAG_SKIP = 1;
    localparam FLAG_DEEMPH = 2;

    // stored fields; all of them are sticky
    reg [2:0] tx_margin_sel;
    reg [FLAG_N-1:0] flag_bits;
    reg [3:0] prev_state;
    // next values, built combinationally below
    reg [2:0] next_tx_margin_sel;
    wire [FLAG_N-1:0] next_flag_bits;
    reg [15:0] next_rdata;
    reg [2:0] next_tx_margin_line;
    reg next_use_serdes_level;
    reg [2:0] next_tx_level;
    reg next_send_modified_comp;
    reg next_skip_insert_en;
    reg next_comp_deemph_3p5;
    reg next_apply_deemph_override;
    // named views of the flag bits
    wire modified_compliance_en;
    wire compliance_skip_insert;
    wire compliance_deemph_sel;
    // bus and training state decodes
    wire [2:0] margin_line;
    wire hit;
    wire wr_hit;
    wire rd_hit;
    wire enter_poll_cfg;
    wire in_comp;
    wire in_rcv_lock;
    wire line_normal;
    genvar fi;

    // training state compare, shared by every state decode
    function state_is(input [3:0] state, input [3:0] code);
        state_is = (state == code);
    endfunction

    // margin code zero leaves the drive level to the serdes controls
    function margin_is_normal(input [2:0] code);
        margin_is_normal = (code == `LCM_MARGIN_NORMAL);
    endfunction

    // register image; bits 15:13 and the lower fields read zero
    function [15:0] pack_ctl2(input [2:0] margin, input [2:0] flags);
        pack_ctl2 = {3'h0, flags, margin, 7'h00};
    endfunction

    // i_rst is the fundamental reset only; hot or link reset never reaches
    // these flops, which is what keeps them sticky
    assign hit = (i_addr == `LCM_OFS_CTL2);
    assign wr_hit = i_wr && hit;
    assign rd_hit = i_rd && hit;

    // entry, not presence: the clear fires once per visit
    assign enter_poll_cfg = state_is(i_ltssm_state, `LCM_ST_POLL_CFG) &&
        !state_is(prev_state, `LCM_ST_POLL_CFG);
    assign in_comp = state_is(i_ltssm_state, `LCM_ST_POLL_COMP);
    assign in_rcv_lock = state_is(i_ltssm_state, `LCM_ST_RCV_LOCK);
    assign line_normal = margin_is_normal(margin_line);

    // flag views, in the order of their register bits
    assign modified_compliance_en = flag_bits[FLAG_MC];
    assign compliance_skip_insert = flag_bits[FLAG_SKIP];
    assign compliance_deemph_sel = flag_bits[FLAG_DEEMPH];

    // previous training state for the entry detector
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prev_state <= `LCM_ST_OTHER;
        end else begin
            prev_state <= i_ltssm_state;
        end
    end

    // margin: the polling clear beats a same-cycle write, so a stale
    // margin never survives a fresh training attempt
    always @* begin
        next_tx_margin_sel = tx_margin_sel;
        if (enter_poll_cfg) begin
            next_tx_margin_sel = `LCM_MARGIN_RST;
        end else if (wr_hit) begin
            next_tx_margin_sel = i_wdata[`LCM_MARGIN_MSB:`LCM_MARGIN_LSB];
        end
    end

    // the flags share one write path, one bit apiece
    generate
        for (fi = 0; fi < FLAG_N; fi = fi + 1) begin : g_flag
            assign next_flag_bits[fi] = wr_hit ?
                i_wdata[`LCM_MC_BIT + fi] : flag_bits[fi];
        end
    endgenerate

    // margin storage; the fundamental reset and polling configuration entry clear it
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_margin_sel <= `LCM_MARGIN_RST;
        end else begin
            tx_margin_sel <= next_tx_margin_sel;
        end
    end

    // flag storage; writes to other addresses leave it alone
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            flag_bits <= {FLAG_N{1'b0}};
        end else begin
            flag_bits <= next_flag_bits;
        end
    end

    // the line copy moves only at receiver lock; a change in mid-stream
    // would upset the partner's receiver
    lcm_margin_apply u_apply (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_margin_reg(tx_margin_sel),
        .i_in_rcv_lock(in_rcv_lock),
        .o_margin_line(margin_line)
    );

    // read image for a hit, zero otherwise, so nothing lingers on the bus
    always @* begin
        next_rdata = 16'h0000;
        if (rd_hit) begin
            next_rdata = pack_ctl2(tx_margin_sel, flag_bits);
        end
    end

    // transmitter controls follow the applied margin, not the field
    always @* begin
        next_tx_margin_line = margin_line;
        next_use_serdes_level = line_normal;
        next_tx_level = margin_line;
        if (line_normal) begin
            next_tx_level = i_serdes_level;
        end
    end

    // compliance controls only matter while in polling compliance
    always @* begin
        next_send_modified_comp = in_comp && modified_compliance_en;
        next_skip_insert_en = in_comp && compliance_skip_insert;
        // the level always shows; the override says when it applies
        next_comp_deemph_3p5 = compliance_deemph_sel;
        next_apply_deemph_override = in_comp && i_comp_by_force;
    end

    // read data stands for the one cycle after the strobe
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    // applied margin code for the transmitter
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tx_margin_line <= `LCM_MARGIN_RST;
        end else begin
            o_tx_margin_line <= next_tx_margin_line;
        end
    end

    // serdes select idles high, since the margin resets to normal
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_use_serdes_level <= 1'b1;
        end else begin
            o_use_serdes_level <= next_use_serdes_level;
        end
    end

    // drive level actually handed to the transmitter
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tx_level <= 3'h0;
        end else begin
            o_tx_level <= next_tx_level;
        end
    end

    // modified pattern request
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_send_modified_comp <= 1'b0;
        end else begin
            o_send_modified_comp <= next_send_modified_comp;
        end
    end

    // skip ordered set insertion request
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_skip_insert_en <= 1'b0;
        end else begin
            o_skip_insert_en <= next_skip_insert_en;
        end
    end

    // compliance de-emphasis, high for the lighter setting
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_comp_deemph_3p5 <= 1'b0;
        end else begin
            o_comp_deemph_3p5 <= next_comp_deemph_3p5;
        end
    end

    // override only for a forced compliance entry
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_apply_deemph_override <= 1'b0;
        end else begin
            o_apply_deemph_override <= next_apply_deemph_override;
        end
    end
endmodule // lcm_link_ctl2

// [bench/lcm_ltssm_model.sv]
`timescale 1ns/10ps
// training side stand-in: follows the requested state one cycle late
module lcm_ltssm_model (input wire i_clk, input wire [3:0] i_goto,
    output reg [3:0] o_state = 4'h0, output wire o_force,
    output wire [2:0] o_level);
    assign o_level = 3'h6; // nonzero so a serdes pick is visible
    assign o_force = (o_state == 4'h2); // forced entry, hot reset done
    always @(posedge i_clk) o_state <= i_goto;
endmodule // lcm_ltssm_model

// [bench/lcm_link_ctl2_asserts.sv]
`timescale 1ns/10ps
module lcm_chk (input wire i_clk, i_rst, i_rd, i_comp_by_force,
    input wire [11:0] i_addr, input wire [15:0] o_rdata,
    input wire [3:0] i_ltssm_state, input wire [2:0] o_tx_margin_line,
    input wire [2:0] o_tx_level, input wire o_use_serdes_level,
    input wire o_send_modified_comp, o_skip_insert_en,
    input wire o_apply_deemph_override);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_rd_reserved: assert property (i_rd |=> o_rdata[15:13] == 3'h0
        && o_rdata[6:0] == 7'h0) else $error("reserved bits set");
    a_bad_addr: assert property (i_rd && i_addr != 12'h070
        |=> o_rdata == 16'h0) else $error("unmapped read not zero");
    a_rd_idle: assert property (!i_rd |=> o_rdata == 16'h0)
        else $error("read data outside its cycle");
    a_margin_hold: assert property ($changed(o_tx_margin_line)
        |-> $past(i_ltssm_state, 2) == 4'h3
        || $past(i_ltssm_state, 3) == 4'h3) else $error("margin moved");
    a_level_pick: assert property (!o_use_serdes_level
        |-> o_tx_level == o_tx_margin_line) else $error("level wrong");
    a_mod_comp: assert property (o_send_modified_comp
        |-> $past(i_ltssm_state) == 4'h2) else $error("modified early");
    a_skip_ins: assert property (o_skip_insert_en
        |-> $past(i_ltssm_state) == 4'h2) else $error("skip early");
    a_deemph_ovr: assert property (!$past(i_rst) |->
        o_apply_deemph_override == ($past(i_ltssm_state) == 4'h2
        && $past(i_comp_by_force))) else $error("override wrong");
    c_mod: cover property (o_send_modified_comp);
    c_ovr: cover property (o_apply_deemph_override);
    c_margin: cover property ($changed(o_tx_margin_line));
endmodule // lcm_chk
bind lcm_link_ctl2 lcm_chk u_chk (.*);

// [bench/lcm_link_ctl2_test.sv]
`timescale 1ns/10ps
module lcm_link_ctl2_test;
    reg i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, rd_d = 0;
    reg [11:0] i_addr = 12'h0;
    reg [15:0] i_wdata = 16'h0, r;
    reg [3:0] go = 4'h0;
    wire [3:0] i_ltssm_state;
    wire [2:0] i_serdes_level, o_tx_margin_line, o_tx_level;
    wire [15:0] o_rdata;
    wire i_comp_by_force, o_use_serdes_level, o_send_modified_comp;
    wire o_skip_insert_en, o_comp_deemph_3p5, o_apply_deemph_override;
    int failures = 0, cmp_count = 0, cyc = 0;
    reg [15:0] exq[$];
    always #5 i_clk = ~i_clk;
    lcm_ltssm_model m (.i_clk(i_clk), .i_goto(go), .o_state(i_ltssm_state),
        .o_force(i_comp_by_force), .o_level(i_serdes_level));
    lcm_link_ctl2 DUT (.*);
    task wr(input [11:0] a, input [15:0] d);
        @(posedge i_clk) begin i_wr <= 1; i_addr <= a; i_wdata <= d; end
        @(posedge i_clk) i_wr <= 0;
    endtask
    task rd(input [11:0] a, input [15:0] e);
        exq.push_back(e);
        @(posedge i_clk) begin i_rd <= 1; i_addr <= a; end
        @(posedge i_clk) i_rd <= 0;
    endtask
    task chk(input [15:0] g, e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %0t got %h want %h", $time, g, e);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // read data checked mid-cycle, away from the edge that drops it
    always @(negedge i_clk) if (rd_d) chk(o_rdata, exq.pop_front());
    always @(posedge i_clk) begin
        rd_d <= i_rd;
        cyc++;
        if (cyc == 3000) begin failures++; test_done; end
    end
    initial begin
        void'($urandom(32'hfe1ade98));
        repeat (2) @(posedge i_clk);
        i_rst <= 0;
        rd(12'h070, 16'h0);
        wr(12'h070, 16'hffff);
        wr(12'h072, 16'h0);
        rd(12'h072, 16'h0);
        rd(12'h070, 16'h1f80);
        repeat (8) begin
            r = 16'($urandom);
            wr(12'h070, r);
            rd(12'h070, r & 16'h1f80);
        end
        $display("register test done");
        wr(12'h070, 16'h0380);
        go <= 4'h1;
        repeat (3) @(posedge i_clk);
        go <= 4'h0;
        rd(12'h070, 16'h0);
        wr(12'h070, 16'h0180);
        repeat (4) @(posedge i_clk);
        #1 chk(o_tx_margin_line, 16'h0);
        go <= 4'h3; // retrain after the margin change
        repeat (6) @(posedge i_clk);
        go <= 4'h0;
        repeat (3) @(posedge i_clk);
        #1 chk({o_use_serdes_level, o_tx_level}, 16'h3);
        wr(12'h070, 16'h1c00);
        go <= 4'h3;
        repeat (6) @(posedge i_clk);
        go <= 4'h2;
        repeat (3) @(posedge i_clk);
        #1 chk({o_use_serdes_level, o_tx_level, o_send_modified_comp,
            o_skip_insert_en, o_comp_deemph_3p5, o_apply_deemph_override},
            16'hef);
        $display("line test done");
        wr(12'h070, 16'h0); // back to defaults after testing
        rd(12'h070, 16'h0);
        @(posedge i_clk) i_rst <= 1;
        repeat (2) @(posedge i_clk);
        i_rst <= 0;
        rd(12'h070, 16'h0);
        repeat (3) @(posedge i_clk);
        $display("reset test done");
        test_done;
    end
endmodule // lcm_link_ctl2_test
